// ---- hw/lar_readout.sv ----
// Serial command receiver, control sequencer, pixel FIFO and transmitter.
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Pixel FIFO
module lar_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             flush_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              do_wr = in_valid_i && in_ready_o;
  wire              do_rd = out_valid_o && out_ready_i;
  assign in_ready_o  = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || flush_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule : lar_fifo

// ============================================================
// Readout top
module lar_readout
  import lar_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   serial_clk_i,
  input  wire logic                   serial_in_line_i,
  output logic                        serial_out_line_o,
  output logic                        integ_reset_o,
  output logic                        integ_run_o,
  output logic                        sample_strobe_o,
  output logic      [6:0]             pix_addr_o,
  input  wire logic [PIXEL_WIDTH-1:0] pix_data_i,
  output logic                        readout_busy_o,
  output lar_zone_cfg_s               left_cfg_o,
  output lar_zone_cfg_s               center_cfg_o,
  output lar_zone_cfg_s               right_cfg_o
);
  // ============================================================
  // Serial clock and input synchronisers
  logic sclk_q1;
  logic sclk_q2;
  logic sclk_q3;
  logic serial_in_line_q1;
  logic serial_in_line_q2;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sclk_q1 <= 1'b0;
      sclk_q2 <= 1'b0;
      sclk_q3 <= 1'b0;
      serial_in_line_q1 <= 1'b1;
      serial_in_line_q2 <= 1'b1;
    end else begin
      sclk_q1 <= serial_clk_i;
      sclk_q2 <= sclk_q1;
      sclk_q3 <= sclk_q2;
      serial_in_line_q1 <= serial_in_line_i;
      serial_in_line_q2 <= serial_in_line_q1;
    end
  end

  wire sclk_rise = sclk_q2 && !sclk_q3; // R1 R12
  wire sclk_fall = !sclk_q2 && sclk_q3; // R1 R12
  // ============================================================
  // Receiver
  lar_rx_state_e rx_state;
  logic [2:0]    rx_bit;
  logic [7:0]    rx_shift;
  logic [3:0]    low_run;
  logic          rx_done;
  wire           brk_hit = !serial_in_line_q2 && (low_run == BREAK_BITS - 4'h1);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_state <= RX_IDLE;
      rx_bit   <= '0;
      rx_shift <= '0;
      low_run  <= '0;
      rx_done  <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (sclk_rise) begin
        if (serial_in_line_q2) begin
          low_run <= '0;
        end else if (low_run != BREAK_BITS) begin
          low_run <= low_run + 4'h1;
        end
        if (brk_hit) begin
          rx_state <= RX_BREAK; // R25
        end else begin
          case (rx_state)
            RX_IDLE: begin
              if (!serial_in_line_q2) begin
                rx_state <= RX_DATA; // R26 R11
                rx_bit   <= '0;
              end
            end
            RX_DATA: begin
              rx_shift <= {serial_in_line_q2, rx_shift[7:1]};
              rx_bit   <= rx_bit + 3'h1;
              if (rx_bit == 3'h7) begin
                rx_state <= RX_IDLE; // R13
                rx_done  <= 1'b1;
              end
            end
            RX_BREAK: begin
              if (serial_in_line_q2) begin
                rx_state <= RX_IDLE;
              end
            end
            default: rx_state <= RX_IDLE;
          endcase
        end
      end
    end
  end
  // ============================================================
  // Command decode
  logic       expect_data;
  logic [4:0] store_addr;
  wire        cmd_act   = rx_done && !expect_data;
  wire  [7:0] cmd       = rx_shift;
  wire        do_reset  = cmd_act && (cmd == CMD_RESET); // R22
  wire        do_abort  = cmd_act && (cmd == CMD_ABORT); // R22
  wire        do_sample = cmd_act && (cmd == CMD_SAMPLE ||
                          cmd == CMD_SAMPLE_READ ||
                          cmd == CMD_SAMPLE_RD_START); // R22
  wire        do_read   = cmd_act && (cmd == CMD_READ ||
                          cmd == CMD_SAMPLE_READ ||
                          cmd == CMD_SAMPLE_RD_START); // R22
  wire        do_start  = cmd_act && (cmd == CMD_START ||
                          cmd == CMD_SAMPLE_RD_START); // R22
  wire        do_store  = cmd_act && (cmd[7:5] == CMD_REG_STORE); // R23
  wire        do_fetch  = cmd_act && (cmd[7:5] == CMD_REG_FETCH); // R23
  wire        stop_read = do_reset || do_abort; // R7

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      expect_data <= 1'b0;
      store_addr  <= '0;
    end else if (sclk_rise && brk_hit) begin
      expect_data <= 1'b0; // R25
    end else if (rx_done) begin
      expect_data <= do_store; // R23
      store_addr  <= cmd[4:0];
    end
  end
  // ============================================================
  // Zone gain and offset settings
  lar_zone_cfg_s cfg [3];
  wire  [1:0]    store_zone = store_addr[2:1];
  wire           store_hit  = rx_done && expect_data &&
                              (store_addr <= REG_ADDR_LAST);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cfg[0] <= ZONE_CFG_RESET;
      cfg[1] <= ZONE_CFG_RESET;
      cfg[2] <= ZONE_CFG_RESET;
    end else if (store_hit) begin
      if (store_addr[0]) begin
        cfg[store_zone].gain <= rx_shift[4:0]; // R8
      end else begin
        cfg[store_zone].offset <= rx_shift; // R9
      end
    end
  end

  assign left_cfg_o   = cfg[0];
  assign center_cfg_o = cfg[1];
  assign right_cfg_o  = cfg[2];

  wire [1:0] fetch_zone = cmd[2:1];
  wire [7:0] fetch_val  = (cmd[4:0] > REG_ADDR_LAST) ? 8'h00 :
                          cmd[0] ? {3'h0, cfg[fetch_zone].gain} :
                          cfg[fetch_zone].offset;
  // ============================================================
  // Integration control
  logic [4:0] start_wait;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      integ_reset_o   <= 1'b1;
      integ_run_o     <= 1'b0;
      sample_strobe_o <= 1'b0;
      start_wait      <= '0;
    end else begin
      sample_strobe_o <= do_sample; // R5
      if (stop_read) begin
        integ_reset_o <= 1'b1; // R3
        integ_run_o   <= 1'b0;
        start_wait    <= '0;
      end else begin
        if (do_sample) begin
          integ_reset_o <= 1'b1; // R5
          integ_run_o   <= 1'b0;
        end
        if (do_start) begin
          start_wait <= START_DELAY; // R21
        end else if (sclk_rise && start_wait != '0) begin
          start_wait <= start_wait - 5'h1;
          if (start_wait == 5'h1) begin
            integ_reset_o <= 1'b0; // R4 R2
            integ_run_o   <= 1'b1;
          end
        end
      end
    end
  end
  // ============================================================
  // Pixel producer into the FIFO
  logic                   prod_active;
  logic [5:0]             read_wait;
  logic                   read_go;
  logic                   fifo_ready;
  logic [PIXEL_WIDTH-1:0] fifo_data;
  logic                   fifo_valid;
  logic                   pop_fifo;
  logic                   tx_busy;
  wire                    push = prod_active && fifo_ready;

  lar_fifo #(
    .WIDTH (PIXEL_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .flush_i     (stop_read || do_read),
    .in_data_i   (pix_data_i),
    .in_valid_i  (prod_active),
    .in_ready_o  (fifo_ready),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (pop_fifo)
  );

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prod_active <= 1'b0;
      pix_addr_o  <= '0;
      read_wait   <= '0;
      read_go     <= 1'b0;
    end else if (stop_read) begin
      prod_active <= 1'b0; // R7
      read_wait   <= '0;
      read_go     <= 1'b0;
    end else if (do_read) begin
      prod_active <= 1'b1; // R6
      pix_addr_o  <= '0;
      read_wait   <= READ_DELAY; // R20
      read_go     <= 1'b0;
    end else begin
      if (push) begin
        if (pix_addr_o == PIXEL_LAST) begin
          prod_active <= 1'b0; // R7
        end else begin
          pix_addr_o <= pix_addr_o + 7'h1; // R24
        end
      end
      if (sclk_rise && read_wait != '0) begin
        read_wait <= read_wait - 6'h1;
        read_go   <= (read_wait == 6'h1);
      end else if (read_go && !prod_active && !fifo_valid && !tx_busy) begin
        read_go <= 1'b0;
      end
    end
  end

  assign readout_busy_o = prod_active || read_wait != '0 || read_go;
  // ============================================================
  // Register fetch timing
  logic [2:0] fetch_wait;
  logic       fetch_go;
  logic [7:0] fetch_byte;
  wire        load_fetch = sclk_fall && !tx_busy && fetch_go;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fetch_wait <= '0;
      fetch_go   <= 1'b0;
      fetch_byte <= '0;
    end else if (do_reset) begin
      fetch_wait <= '0;
      fetch_go   <= 1'b0;
    end else if (do_fetch) begin
      fetch_byte <= fetch_val;
      fetch_wait <= FETCH_DELAY; // R19
    end else if (sclk_rise && fetch_wait != '0) begin
      fetch_wait <= fetch_wait - 3'h1;
      fetch_go   <= (fetch_wait == 3'h1);
    end else if (load_fetch) begin
      fetch_go <= 1'b0;
    end
  end
  // ============================================================
  // Transmitter
  lar_tx_state_e tx_state;
  logic [8:0]    tx_shift;
  logic [3:0]    tx_left;
  wire  [7:0]    tx_word = fetch_go ? fetch_byte : fifo_data;

  assign tx_busy  = (tx_state == TX_BITS);
  assign pop_fifo = sclk_fall && !tx_busy && !fetch_go &&
                    read_go && fifo_valid; // R15
  wire   tx_load  = load_fetch || pop_fifo;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tx_state          <= TX_IDLE;
      tx_shift          <= '1;
      tx_left           <= '0;
      serial_out_line_o <= 1'b1; // R27
    end else if (stop_read && !fetch_go) begin
      tx_state          <= TX_IDLE; // R7
      serial_out_line_o <= 1'b1;
    end else if (tx_load) begin
      tx_state          <= TX_BITS;
      serial_out_line_o <= 1'b0; // R24 R6
      tx_shift          <= {1'b1, tx_word}; // R24
      tx_left           <= TX_FRAME_BITS;
    end else if (sclk_fall && tx_busy) begin
      serial_out_line_o <= tx_shift[0]; // R12
      tx_shift          <= {1'b1, tx_shift[8:1]};
      tx_left           <= tx_left - 4'h1;
      if (tx_left == 4'h1) begin
        tx_state <= TX_IDLE; // R14
      end
    end
  end

endmodule : lar_readout

`default_nettype wire

// ---- hw/lar_pkg.sv ----
// Constants, types and command codes for the linear array serial readout.
// Summary of operation
// R1: All logic runs from the host serial clock, sampled and edge-detected here.
// R2: Normal cycle: reset, start integration, integrate, sample, then read pixels.
// R3: Reset command forces integrators to zero and holds them in reset.
// R4: Integration start command releases integrators, beginning the integration period.
// R5: Sample command ends integration and captures every pixel into its hold store.
// R6: Pixel read command converts sampled values to 8-bit codes and shifts them out.
// R7: All 102 pixels go out in order unless aborted or reset.
// R8: Three independent 5-bit gains, one per 34-pixel zone.
// R9: Three 8-bit sign-magnitude offsets, MSB set means negative.
// R10: Host must program all gains and offsets after power-up.
// R11: A character is a start bit, 8 data bits, one or more stops.
// R12: Input sampled on rising serial clock, output changed on falling edge.
// R13: Receiver accepts a start bit right after the last data bit.
// R14: Continuous pixel output has exactly one stop bit between words.
// R15: Receiver and transmitter run independently; commands accepted during readout.
// R16: Host must not request register reads during a pixel readout.
// R17: Host should not change gain or offset during a readout.
// R18: Host gives at least 5 clocks after each command's stop bit.
// R19: Register contents start shifting out 4 clocks after the read command.
// R20: First pixel goes out 44 clocks after the pixel read command.
// R21: Integration starts 22 clocks after the start command.
// R22: Action codes 1B, 08, 10, 02, 19, 12 and 16 hex.
// R23: Register write is 40h plus address then data; read is 60h plus address.
// R24: Pixel bytes go LSB first, 0 start, 1 stop, pixels 0 to 101.
// R25: Ten or more low input bits reinitialise the command byte tracker.
// R26: Idle receiver takes first low bit as start, then collects eight bits.
// R27: Serial output idles high between characters.
package lar_pkg;

  localparam logic [7:0] CMD_RESET       = 8'h1B;
  localparam logic [7:0] CMD_START       = 8'h08;
  localparam logic [7:0] CMD_SAMPLE      = 8'h10;
  localparam logic [7:0] CMD_READ        = 8'h02;
  localparam logic [7:0] CMD_ABORT       = 8'h19;
  localparam logic [7:0] CMD_SAMPLE_READ = 8'h12;
  localparam logic [7:0] CMD_SAMPLE_RD_START = 8'h16;
  localparam logic [2:0] CMD_REG_STORE   = 3'h2;
  localparam logic [2:0] CMD_REG_FETCH   = 3'h3;

  localparam logic [6:0] PIXEL_LAST    = 7'h65;
  localparam logic [4:0] REG_ADDR_LAST = 5'h05;
  localparam logic [3:0] BREAK_BITS    = 4'hA;
  localparam logic [4:0] START_DELAY   = 5'h16;
  localparam logic [5:0] READ_DELAY    = 6'h2C;
  localparam logic [2:0] FETCH_DELAY   = 3'h4;
  localparam logic [3:0] TX_FRAME_BITS = 4'h9;
  localparam int         FIFO_DEPTH    = 8;
  localparam int         PIXEL_WIDTH   = 8;

  typedef struct packed {
    logic [4:0] gain;
    logic [7:0] offset;
  } lar_zone_cfg_s;

  localparam lar_zone_cfg_s ZONE_CFG_RESET = '0;

  typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_BREAK} lar_rx_state_e;
  typedef enum logic {TX_IDLE, TX_BITS} lar_tx_state_e;

endpackage : lar_pkg

// ---- sim/lar_readout_props.sv ----
// Concurrent checks on the ports of the readout top, bound into it.
`timescale 1ns/1ps
`default_nettype none
module lar_readout_props
  import lar_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       serial_out_line_o,
  input wire logic       integ_reset_o,
  input wire logic       integ_run_o,
  input wire logic       sample_strobe_o,
  input wire logic [6:0] pix_addr_o,
  input wire logic       readout_busy_o
);
  // ====================
  // Helper logic
  logic [7:0] low_cnt;

  // Counts clocks the output has been low; a frame holds at most nine lows.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || serial_out_line_o) begin
      low_cnt <= 8'h00;
    end else begin
      low_cnt <= low_cnt + 8'h01;
    end
  end

  // ====================
  // Properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_reset_state: assert property ($rose(rst_n_i) |->
    serial_out_line_o && integ_reset_o && !integ_run_o && !sample_strobe_o
    && pix_addr_o == 7'h00 && !readout_busy_o)
    else $error("outputs wrong after reset");
  a_run_excl: assert property (!(integ_run_o && integ_reset_o))
    else $error("integrating while held in reset");
  a_strobe_single: assert property (sample_strobe_o |=> !sample_strobe_o)
    else $error("sample strobe longer than one clock");
  a_strobe_resets: assert property (sample_strobe_o |->
    ##[0:2] (integ_reset_o && !integ_run_o))
    else $error("sample did not end integration");
  a_addr_bound: assert property (pix_addr_o <= PIXEL_LAST)
    else $error("pixel index beyond last pixel");
  a_addr_order: assert property ($changed(pix_addr_o) |->
    pix_addr_o == $past(pix_addr_o) + 7'h01 || pix_addr_o == 7'h00)
    else $error("pixel index out of order");
  a_lead_high: assert property ($rose(readout_busy_o) |->
    serial_out_line_o throughout (##300 1'b1))
    else $error("pixel data started too early");
  a_low_run: assert property (low_cnt <= 8'h4A)
    else $error("output low longer than one frame");

  cover property ($rose(integ_run_o) && readout_busy_o);
  cover property (sample_strobe_o && readout_busy_o);
  cover property ($fell(readout_busy_o) && pix_addr_o != 7'h00);
endmodule : lar_readout_props

bind lar_readout lar_readout_props u_props (
  .clk_i(clk_i),
  .rst_n_i(rst_n_i),
  .serial_out_line_o(serial_out_line_o),
  .integ_reset_o(integ_reset_o),
  .integ_run_o(integ_run_o),
  .sample_strobe_o(sample_strobe_o),
  .pix_addr_o(pix_addr_o),
  .readout_busy_o(readout_busy_o)
);
`default_nettype wire

// ---- sim/lar_host_model.sv ----
// Host controller model: serial clock, command line and output deframer.
`timescale 1ns/1ps
`default_nettype none
module lar_host_model (
  input  wire logic clk_i,
  output logic      serial_clk_o,
  output logic      serial_in_line_o,
  input  wire logic serial_out_line_i
);
  int         tick_n = 0;
  int         rx_bit = -1;
  logic [7:0] rx_sh;
  logic [7:0] rx_q[$];
  int         st_q[$];

  // The serial clock stands low between transfers.
  initial begin
    serial_clk_o = 1'b0;
    serial_in_line_o = 1'b1;
  end

  // ====================
  // Bit clock: data set while low, output taken late in the high phase.
  task automatic tick(input logic din);
    logic d;
    serial_in_line_o = din;
    repeat (4) @(negedge clk_i);
    serial_clk_o = 1'b1;
    repeat (4) @(negedge clk_i);
    d = serial_out_line_i;
    serial_clk_o = 1'b0;
    tick_n++;
    if (rx_bit < 0) begin
      if (d === 1'b0) begin
        rx_bit = 0;
        st_q.push_back(tick_n);
      end
    end else if (rx_bit < 8) begin
      rx_sh = {d, rx_sh[7:1]};
      rx_bit++;
    end else begin
      if (d === 1'b1) begin
        rx_q.push_back(rx_sh);
      end
      rx_bit = -1;
    end
  endtask : tick

  // Sends a byte with no stop bit, so the next start may follow at once.
  task automatic send(input logic [7:0] b);
    tick(1'b0);
    for (int i = 0; i < 8; i++) begin
      tick(b[i]);
    end
  endtask : send

  task automatic idle(input int n);
    repeat (n) tick(1'b1);
  endtask : idle
endmodule : lar_host_model
`default_nettype wire

// ---- sim/lar_readout_test.sv ----
// Self-checking bench for the readout top driven by the host model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    num_checks++; \
    if ((g) !== (e)) begin \
      error_cnt++; \
      $display("mismatch %s exp %0h got %0h", nm, e, g); \
    end \
  end
module lar_readout_test
  import lar_pkg::*;
();
  logic          clk_i = 1'b0;
  logic          rst_n_i = 1'b0;
  logic          sclk;
  logic          serial_in_line;
  logic          serial_out_line;
  logic          integ_reset;
  logic          integ_run;
  logic          strobe;
  logic          busy;
  logic [6:0]    pix_addr;
  logic [7:0]    pix_data;
  logic [7:0]    pix_key = 8'h00;
  logic [31:0]   seed = 32'h750f;
  logic [7:0]    shadow[6] = '{default: 8'h00};
  lar_zone_cfg_s cfg[3];
  lar_zone_cfg_s left_cfg;
  lar_zone_cfg_s center_cfg;
  lar_zone_cfg_s right_cfg;
  int            error_cnt = 0;
  int            num_checks = 0;
  int            strobes = 0;

  always #50 clk_i = ~clk_i;
  assign pix_data = {1'b0, pix_addr} ^ pix_key;
  assign cfg[0]   = left_cfg;
  assign cfg[1]   = center_cfg;
  assign cfg[2]   = right_cfg;

  lar_readout u_dut (
    .clk_i             (clk_i),
    .rst_n_i           (rst_n_i),
    .serial_clk_i      (sclk),
    .serial_in_line_i  (serial_in_line),
    .serial_out_line_o (serial_out_line),
    .integ_reset_o     (integ_reset),
    .integ_run_o       (integ_run),
    .sample_strobe_o   (strobe),
    .pix_addr_o        (pix_addr),
    .pix_data_i        (pix_data),
    .readout_busy_o    (busy),
    .left_cfg_o        (left_cfg),
    .center_cfg_o      (center_cfg),
    .right_cfg_o       (right_cfg)
  );
  lar_host_model u_host (
    .clk_i             (clk_i),
    .serial_clk_o      (sclk),
    .serial_in_line_o  (serial_in_line),
    .serial_out_line_i (serial_out_line)
  );

  // Counted on the falling edge, where the registered pulse has settled.
  always @(negedge clk_i) begin
    if (strobe === 1'b1) begin
      strobes++;
    end
  end

  // ====================
  // Helpers
  function automatic logic [7:0] rnd8();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : rnd8

  // Gains read back in five bits; unmapped places read as zero.
  function automatic logic [7:0] exp_reg(input int a);
    if (a > 5) return 8'h00;
    return a[0] ? {3'b000, shadow[a][4:0]} : shadow[a];
  endfunction : exp_reg

  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask : done

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic fetch(input int a);
    int c;
    u_host.rx_q.delete();
    u_host.st_q.delete();
    u_host.send(8'h60 | 8'(a));
    c = u_host.tick_n;
    u_host.idle(16);
    `CHK("fetch count", 1, u_host.rx_q.size())
    `CHK("fetch lead", c + 5, u_host.st_q[0])
    `CHK("fetch data", exp_reg(a), u_host.rx_q[0])
  endtask : fetch

  // Readout with an optional command sent in the middle of the stream.
  task automatic read_pix(input logic [7:0] cmd, input logic [7:0] mid,
                          input int n_ok, input int n_cnt);
    int c;
    pix_key = rnd8();
    u_host.rx_q.delete();
    u_host.st_q.delete();
    u_host.send(cmd);
    c = u_host.tick_n;
    u_host.idle(200);
    if (mid != 8'h00) begin
      u_host.send(mid);
    end else begin
      u_host.idle(9);
    end
    u_host.idle(861);
    `CHK("pixel count", n_cnt, u_host.rx_q.size())
    `CHK("first start", c + 45, u_host.st_q[0])
    for (int i = 0; i < n_ok; i++) begin
      `CHK("pixel", {1'b0, i[6:0]} ^ pix_key, u_host.rx_q[i])
    end
    for (int i = 1; i < n_cnt; i++) begin
      `CHK("spacing", 10, u_host.st_q[i] - u_host.st_q[i - 1])
    end
  endtask : read_pix

  // ====================
  // Main sequence
  initial begin
    logic [7:0] d;
    int         s0;
    repeat (20) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    `CHK("out idle", 1'b1, serial_out_line)
    `CHK("integ reset", 1'b1, integ_reset)
    `CHK("left cfg", ZONE_CFG_RESET, cfg[0])
    done("reset");
    u_host.idle(2);
    u_host.send(8'h41);
    repeat (12) u_host.tick(1'b0);
    u_host.idle(2);
    fetch(1);
    `CHK("break drop", 5'h00, cfg[0].gain)
    done("break");
    for (int a = 0; a < 7; a++) begin
      d = rnd8();
      if (a < 6) begin
        shadow[a] = d;
      end
      u_host.send(8'h40 | 8'(a));
      u_host.send(d);
      u_host.idle(5);
    end
    for (int z = 0; z < 3; z++) begin
      `CHK("offset", shadow[2 * z], cfg[z].offset)
      `CHK("gain", shadow[2 * z + 1][4:0], cfg[z].gain)
    end
    for (int a = 0; a < 7; a++) begin
      fetch(a);
    end
    done("registers");
    u_host.send(CMD_RESET);
    u_host.idle(5);
    `CHK("reset holds", 1'b1, integ_reset)
    u_host.send(CMD_START);
    u_host.idle(20);
    `CHK("not yet run", 1'b0, integ_run)
    u_host.idle(3);
    `CHK("running", 1'b1, integ_run)
    `CHK("released", 1'b0, integ_reset)
    s0 = strobes;
    u_host.send(CMD_SAMPLE);
    u_host.idle(5);
    `CHK("one strobe", s0 + 1, strobes)
    `CHK("run ends", 1'b0, integ_run)
    done("integrate");
    read_pix(CMD_READ, CMD_START, 102, 102);
    `CHK("start in readout", 1'b1, integ_run)
    `CHK("busy done", 1'b0, busy)
    s0 = strobes;
    read_pix(CMD_SAMPLE_READ, CMD_ABORT, 16, 17);
    `CHK("abort resets", 1'b1, integ_reset)
    `CHK("sample read", s0 + 1, strobes)
    read_pix(CMD_SAMPLE_RD_START, 8'h00, 102, 102);
    `CHK("restart runs", 1'b1, integ_run)
    read_pix(CMD_READ, CMD_RESET, 16, 17);
    `CHK("reset stops", 1'b0, busy)
    done("readout");
    end_of_test();
  end

  initial begin
    repeat (80000) @(posedge clk_i);
    error_cnt++;
    end_of_test();
  end
endmodule : lar_readout_test
`default_nettype wire
